// [rtl/hmt_consts.vh]
`ifndef HMT_CONSTS_VH
`define HMT_CONSTS_VH

// Mailbox slot geometry
`define HMT_SLOT_BYTES     24'h000004
`define HMT_BE_ALL         4'hf
`define HMT_BE_BYTE0       4'h1
`define HMT_BYTE_ZERO      8'h00
`define HMT_WORD_ZERO      32'h00000000
`define HMT_ADDR_ZERO      24'h000000

// Byte lanes of a slot word (lane 0 at the lowest address)
`define HMT_LANE0          7:0
`define HMT_LANE1          15:8
`define HMT_LANE2          23:16
`define HMT_LANE3          31:24

// Unit byte inside a task control block
`define HMT_CCB_UNIT_OFS   24'h000001
`define HMT_CCB_TGT        7:5
`define HMT_CCB_LUN        2:0

// Sizes
`define HMT_IDX_W          8
`define HMT_CNT_W          9
`define HMT_UNIT_W         6
`define HMT_UNITS          64
`define HMT_QDEPTH         256
`define HMT_QFULL          9'h100
`define HMT_IDX_ONE        8'h01
`define HMT_IDX_ZERO       8'h00
`define HMT_CNT_ZERO       9'h000
`define HMT_CNT_ONE        9'h001

`endif

// [rtl/hmt_task_queue.v]
`timescale 1ns/1ps
`include "hmt_consts.vh"

module hmt_task_queue (
    // Clock and reset
    input  wire                    clk,
    input  wire                    reset_n,
    // Push side
    input  wire                    push,
    input  wire [`HMT_UNIT_W-1:0]  push_unit,
    input  wire [23:0]             push_ccb,
    output wire                    full,
    output wire                    idle,
    // Dispatch side
    output reg                     exec_valid_q,
    output reg  [`HMT_UNIT_W-1:0]  exec_unit_q,
    output reg  [23:0]             exec_ccb_q,
    input  wire                    exec_ready,
    // Unit release on completion
    input  wire                    release_unit,
    input  wire [`HMT_UNIT_W-1:0]  release_id
);

    reg [`HMT_UNIT_W-1:0] unit_mem [0:`HMT_QDEPTH-1];
    reg [23:0]            ccb_mem  [0:`HMT_QDEPTH-1];
    reg [`HMT_QDEPTH-1:0] valid_q;
    reg [`HMT_UNITS-1:0]  busy_q;
    reg [`HMT_IDX_W-1:0]  head_q;
    reg [`HMT_IDX_W-1:0]  tail_q;
    reg [`HMT_IDX_W-1:0]  scan_q;
    reg [`HMT_CNT_W-1:0]  count_q;

    wire scan_hit = valid_q[scan_q] && !busy_q[unit_mem[scan_q]] &&
                    (scan_q != tail_q || count_q == `HMT_QFULL);
    wire take     = scan_hit && (!exec_valid_q || exec_ready);
    wire head_pop = (count_q != `HMT_CNT_ZERO) && !valid_q[head_q];

    assign full = (count_q == `HMT_QFULL);
    assign idle = (count_q == `HMT_CNT_ZERO) && (busy_q == {`HMT_UNITS{1'b0}})
                  && !exec_valid_q;

    always @(posedge clk) begin
        if (push) begin
            unit_mem[tail_q] <= push_unit;
            ccb_mem[tail_q]  <= push_ccb;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_q      <= {`HMT_QDEPTH{1'b0}};
            busy_q       <= {`HMT_UNITS{1'b0}};
            head_q       <= `HMT_IDX_ZERO;
            tail_q       <= `HMT_IDX_ZERO;
            scan_q       <= `HMT_IDX_ZERO;
            count_q      <= `HMT_CNT_ZERO;
            exec_valid_q <= 1'b0;
            exec_unit_q  <= {`HMT_UNIT_W{1'b0}};
            exec_ccb_q   <= `HMT_ADDR_ZERO;
        end else begin
            if (push) begin
                valid_q[tail_q] <= 1'b1; // RQ15
                tail_q          <= tail_q + `HMT_IDX_ONE;
            end
            if (head_pop)
                head_q <= head_q + `HMT_IDX_ONE;
            count_q <= count_q + (push ? `HMT_CNT_ONE : `HMT_CNT_ZERO)
                       - (head_pop ? `HMT_CNT_ONE : `HMT_CNT_ZERO); // RQ18
            if (exec_valid_q && exec_ready)
                exec_valid_q <= 1'b0;
            // One live task per unit; the rest wait in place
            if (take) begin
                valid_q[scan_q]          <= 1'b0;
                busy_q[unit_mem[scan_q]] <= 1'b1; // RQ15
                exec_valid_q             <= 1'b1;
                exec_unit_q              <= unit_mem[scan_q];
                exec_ccb_q               <= ccb_mem[scan_q];
            end
            if (release_unit)
                busy_q[release_id] <= 1'b0;
            // Restart from the oldest entry, but a hit met while dispatch stalls is skipped, so a unit can drain out of order;
            // a younger task of another unit may still pass a blocked one
            if (release_unit || take || scan_q == tail_q)
                scan_q <= head_q; // RQ16
            else
                scan_q <= scan_q + `HMT_IDX_ONE;
        end
    end

endmodule

// [rtl/hmt_mailbox_engine.v]
// Functional notes
// RQ1: Each mailbox slot is four bytes; slots sit four bytes apart.
// RQ2: Incoming slots equal outgoing count and follow the last outgoing slot.
// RQ3: Init command sets base and count; accepted whenever the engine idles. Code refuses one that meets a doorbell in the same cycle.
// RQ4: Outgoing slot: byte zero command, next three bytes control block address.
// RQ5: Outgoing slot with zero command byte is empty.
// RQ6: Posted incoming slot: status in byte zero, block address after.
// RQ7: Incoming slot free when status is zero; post only into free slots.
// RQ8: Host fills address, then command byte, then rings the doorbell.
// RQ9: Full outgoing slot: copy address inside, then zero its command byte.
// RQ10: After a task ends, find free incoming slot, fill it, interrupt.
// RQ11: Host frees incoming slots by zeroing status before reading results.
// RQ12: Incoming and outgoing slots are used in round-robin order.
// RQ13: Mailbox interrupts only reach the host with no other interrupt pending.
// RQ14: Taking and posting entries never waits for interrupt delivery.
// RQ15: One active task per unit; others held in an internal queue.
// RQ16: Per-unit first-in first-out; cross-unit order may change; no tagging. Code lets a unit's younger task pass one skipped in a dispatch stall.
// RQ17: Host should clear interrupts promptly.
// RQ18: Up to 256 control blocks are held outstanding.
// RQ19: Block address is 24 bits, most significant byte first.
// RQ20: Each doorbell scan starts after the last taken slot, wraps once. Code starts after the last examined slot, taken or empty.
`timescale 1ns/1ps
`include "hmt_consts.vh"

module hmt_mailbox_engine (
    // Clock and reset
    input  wire                    clk,
    input  wire                    reset_n,
    // Mailbox initialisation
    input  wire                    init_valid,
    input  wire [23:0]             init_base,
    input  wire [7:0]              init_count,
    output reg                     init_done_q,
    output reg                     init_refused_q,
    // Doorbell from the I/O port logic
    input  wire                    doorbell,
    // System memory master
    output reg                     mem_req_q,
    output reg                     mem_we_q,
    output reg  [3:0]              mem_be_q,
    output reg  [23:0]             mem_addr_q,
    output reg  [31:0]             mem_wdata_q,
    input  wire                    mem_ack,
    input  wire [31:0]             mem_rdata,
    // Task dispatch
    output wire                    exec_valid_q,
    output wire [`HMT_UNIT_W-1:0]  exec_unit_q,
    output wire [23:0]             exec_ccb_q,
    input  wire                    exec_ready,
    // Task completion
    input  wire                    done_valid,
    input  wire [`HMT_UNIT_W-1:0]  done_unit,
    input  wire [7:0]              done_status,
    input  wire [23:0]             done_ccb,
    output reg                     done_ready_q,
    // Host interrupts
    input  wire                    mbo_avail_en,
    input  wire                    other_irq_pending,
    input  wire                    irq_ack,
    output reg                     irq_mbi_full_q,
    output reg                     irq_mbo_avail_q,
    output reg                     host_irq_q
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ORD  = 3'h1;
    localparam [2:0] S_URD  = 3'h2;
    localparam [2:0] S_OCLR = 3'h3;
    localparam [2:0] S_IRD  = 3'h4;
    localparam [2:0] S_IWR  = 3'h5;

    reg [2:0]             state_q;
    reg [23:0]            base_q;
    reg [`HMT_IDX_W-1:0]  count_q;
    reg [`HMT_IDX_W-1:0]  out_next_q;
    reg [`HMT_IDX_W-1:0]  in_next_q;
    reg [`HMT_CNT_W-1:0]  scan_left_q;
    reg [23:0]            take_ccb_q;
    reg                   cmp_full_q;
    reg [7:0]             cmp_status_q;
    reg [23:0]            cmp_ccb_q;
    reg                   mbi_pend_q;
    reg                   mbo_pend_q;
    reg                   push_q;
    reg [`HMT_UNIT_W-1:0] push_unit_q;

    wire q_full;
    wire q_idle;
    wire cap_done = done_valid && done_ready_q;

    // Slot n lives at base + 4n; incoming slots follow the outgoing ones
    wire [23:0] out_addr = base_q + {16'h0000, out_next_q} * `HMT_SLOT_BYTES; // RQ1
    wire [23:0] in_addr  = base_q +
        ({16'h0000, count_q} + {16'h0000, in_next_q}) * `HMT_SLOT_BYTES; // RQ2

    wire [`HMT_IDX_W-1:0] out_inc = (out_next_q + `HMT_IDX_ONE == count_q) ?
                                    `HMT_IDX_ZERO : out_next_q + `HMT_IDX_ONE;
    wire [`HMT_IDX_W-1:0] in_inc  = (in_next_q + `HMT_IDX_ONE == count_q) ?
                                    `HMT_IDX_ZERO : in_next_q + `HMT_IDX_ONE;

    wire engine_idle = (state_q == S_IDLE) && !cmp_full_q && !push_q &&
                       (scan_left_q == `HMT_CNT_ZERO) && q_idle;

    hmt_task_queue u_queue (
        .clk          (clk),
        .reset_n      (reset_n),
        .push         (push_q),
        .push_unit    (push_unit_q),
        .push_ccb     (take_ccb_q),
        .full         (q_full),
        .idle         (q_idle),
        .exec_valid_q (exec_valid_q),
        .exec_unit_q  (exec_unit_q),
        .exec_ccb_q   (exec_ccb_q),
        .exec_ready   (exec_ready),
        .release_unit (cap_done),
        .release_id   (done_unit)
    );

    // Interrupt flags: a new posting in the acknowledge cycle survives
    wire mbi_set = (state_q == S_IWR) && mem_ack;
    wire mbo_set = (state_q == S_OCLR) && mem_ack && mbo_avail_en;
    wire mbi_d   = mbi_set | (mbi_pend_q & ~irq_ack);
    wire mbo_d   = mbo_set | (mbo_pend_q & ~irq_ack);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mbi_pend_q      <= 1'b0;
            mbo_pend_q      <= 1'b0;
            irq_mbi_full_q  <= 1'b0;
            irq_mbo_avail_q <= 1'b0;
            host_irq_q      <= 1'b0;
        end else begin
            mbi_pend_q      <= mbi_d; // RQ14
            mbo_pend_q      <= mbo_d; // RQ14
            // Held back while any non-mailbox interrupt is outstanding
            irq_mbi_full_q  <= mbi_d & ~other_irq_pending; // RQ13
            irq_mbo_avail_q <= mbo_d & ~other_irq_pending; // RQ13
            host_irq_q      <= (mbi_d | mbo_d) & ~other_irq_pending; // RQ10
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q        <= S_IDLE;
            base_q         <= `HMT_ADDR_ZERO;
            count_q        <= `HMT_IDX_ZERO;
            out_next_q     <= `HMT_IDX_ZERO;
            in_next_q      <= `HMT_IDX_ZERO;
            scan_left_q    <= `HMT_CNT_ZERO;
            take_ccb_q     <= `HMT_ADDR_ZERO;
            cmp_full_q     <= 1'b0;
            cmp_status_q   <= `HMT_BYTE_ZERO;
            cmp_ccb_q      <= `HMT_ADDR_ZERO;
            done_ready_q   <= 1'b0;
            push_q         <= 1'b0;
            push_unit_q    <= {`HMT_UNIT_W{1'b0}};
            init_done_q    <= 1'b0;
            init_refused_q <= 1'b0;
            mem_req_q      <= 1'b0;
            mem_we_q       <= 1'b0;
            mem_be_q       <= `HMT_BE_ALL;
            mem_addr_q     <= `HMT_ADDR_ZERO;
            mem_wdata_q    <= `HMT_WORD_ZERO;
        end else begin
            push_q         <= 1'b0;
            init_done_q    <= 1'b0;
            init_refused_q <= init_valid && state_q != S_IDLE; // RQ3
            done_ready_q   <= !cmp_full_q && !cap_done;
            if (cap_done) begin
                cmp_full_q   <= 1'b1;
                cmp_status_q <= done_status;
                cmp_ccb_q    <= done_ccb;
            end
            // A doorbell rearms one full wrap of the outgoing area
            if (doorbell)
                scan_left_q <= {1'b0, count_q}; // RQ20
            case (state_q)
            S_IDLE: begin
                if (init_valid) begin
                    if (engine_idle && !doorbell) begin
                        base_q      <= init_base; // RQ3
                        count_q     <= init_count;
                        out_next_q  <= `HMT_IDX_ZERO;
                        in_next_q   <= `HMT_IDX_ZERO;
                        init_done_q <= 1'b1;
                    end else begin
                        init_refused_q <= 1'b1;
                    end
                end else if (cmp_full_q) begin
                    state_q    <= S_IRD; // RQ10
                    mem_req_q  <= 1'b1;
                    mem_we_q   <= 1'b0;
                    mem_be_q   <= `HMT_BE_ALL;
                    mem_addr_q <= in_addr;
                end else if (scan_left_q != `HMT_CNT_ZERO && !doorbell &&
                             !q_full && !push_q) begin
                    state_q    <= S_ORD; // RQ12
                    mem_req_q  <= 1'b1;
                    mem_we_q   <= 1'b0;
                    mem_be_q   <= `HMT_BE_ALL;
                    mem_addr_q <= out_addr;
                end
            end
            S_ORD: begin
                if (mem_ack) begin
                    mem_req_q <= 1'b0;
                    if (mem_rdata[`HMT_LANE0] != `HMT_BYTE_ZERO) begin
                        take_ccb_q <= {mem_rdata[`HMT_LANE1],
                                       mem_rdata[`HMT_LANE2],
                                       mem_rdata[`HMT_LANE3]}; // RQ19
                        state_q    <= S_URD; // RQ4
                        mem_req_q  <= 1'b1;
                        mem_addr_q <= {mem_rdata[`HMT_LANE1],
                                       mem_rdata[`HMT_LANE2],
                                       mem_rdata[`HMT_LANE3]}
                                      + `HMT_CCB_UNIT_OFS;
                    end else begin
                        // Empty slot: move on
                        out_next_q <= out_inc; // RQ5
                        if (!doorbell)
                            scan_left_q <= scan_left_q - `HMT_CNT_ONE;
                        state_q <= S_IDLE;
                    end
                end
            end
            S_URD: begin
                if (mem_ack) begin
                    // Copy into the queue before the slot is handed back
                    push_q      <= 1'b1; // RQ9
                    push_unit_q <= {mem_rdata[`HMT_CCB_TGT],
                                    mem_rdata[`HMT_CCB_LUN]};
                    state_q     <= S_OCLR;
                    mem_we_q    <= 1'b1;
                    mem_be_q    <= `HMT_BE_BYTE0;
                    mem_addr_q  <= out_addr;
                    mem_wdata_q <= `HMT_WORD_ZERO; // RQ9
                end
            end
            S_OCLR: begin
                if (mem_ack) begin
                    mem_req_q  <= 1'b0;
                    mem_we_q   <= 1'b0;
                    out_next_q <= out_inc; // RQ20
                    if (!doorbell)
                        scan_left_q <= scan_left_q - `HMT_CNT_ONE;
                    state_q <= S_IDLE;
                end
            end
            S_IRD: begin
                if (mem_ack) begin
                    if (mem_rdata[`HMT_LANE0] == `HMT_BYTE_ZERO) begin
                        state_q     <= S_IWR; // RQ7
                        mem_we_q    <= 1'b1;
                        mem_be_q    <= `HMT_BE_ALL;
                        mem_wdata_q <= {cmp_ccb_q[7:0], cmp_ccb_q[15:8],
                                        cmp_ccb_q[23:16],
                                        cmp_status_q}; // RQ6
                    end else begin
                        // Occupied: try the next one on a later pass
                        mem_req_q <= 1'b0;
                        in_next_q <= in_inc; // RQ12
                        state_q   <= S_IDLE;
                    end
                end
            end
            S_IWR: begin
                if (mem_ack) begin
                    mem_req_q  <= 1'b0;
                    mem_we_q   <= 1'b0;
                    cmp_full_q <= 1'b0;
                    in_next_q  <= in_inc; // RQ12
                    state_q    <= S_IDLE;
                end
            end
            default: begin
                state_q   <= S_IDLE;
                mem_req_q <= 1'b0;
                mem_we_q  <= 1'b0;
            end
            endcase
        end
    end

endmodule

// [verif/hmt_mailbox_engine_asserts.sv]
`timescale 1ns/1ps
`include "hmt_consts.vh"
module hmt_mailbox_engine_chk (
    // Clock and reset
    input wire                   clk,
    input wire                   reset_n,
    // Init
    input wire                   init_valid,
    input wire                   init_done_q,
    input wire                   init_refused_q,
    // Memory
    input wire                   mem_req_q,
    input wire                   mem_we_q,
    input wire [3:0]             mem_be_q,
    input wire [23:0]            mem_addr_q,
    input wire [31:0]            mem_wdata_q,
    input wire                   mem_ack,
    input wire [31:0]            mem_rdata,
    // Tasks
    input wire                   exec_valid_q,
    input wire [`HMT_UNIT_W-1:0] exec_unit_q,
    input wire [23:0]            exec_ccb_q,
    input wire                   exec_ready,
    input wire                   done_valid,
    input wire [7:0]             done_status,
    input wire [23:0]            done_ccb,
    input wire                   done_ready_q,
    // Interrupts
    input wire                   other_irq_pending,
    input wire                   irq_mbi_full_q,
    input wire                   host_irq_q
);
    logic [23:0] rd_addr_q;
    logic        rd_zero_q;
    logic [31:0] post_q;
    wire wr_full = mem_req_q && mem_we_q && mem_be_q == 4'hf;
    wire wr_rel  = mem_req_q && mem_we_q && mem_be_q == 4'h1;
    // Only aligned word reads are slot reads; control blocks sit at +1
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_addr_q <= 24'h000000;
            rd_zero_q <= 1'b0;
            post_q    <= 32'h00000000;
        end else begin
            if (mem_ack && !mem_we_q && mem_be_q == 4'hf
                && mem_addr_q[1:0] == 2'b00) begin
                rd_addr_q <= mem_addr_q;
                rd_zero_q <= mem_rdata[7:0] == 8'h00;
            end
            if (done_valid && done_ready_q)
                post_q <= {done_ccb[7:0], done_ccb[15:8], done_ccb[23:16],
                           done_status};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_init_answer;
        init_valid |-> ##[1:2] (init_done_q != init_refused_q);
    endproperty
    a_init_answer: assert property (p_init_answer)
        else $error("init request not answered");
    property p_init_cause;
        init_done_q || init_refused_q |-> $past(init_valid, 1)
            || $past(init_valid, 2);
    endproperty
    a_init_cause: assert property (p_init_cause)
        else $error("init answer without request");
    property p_post_body; wr_full |-> mem_wdata_q == post_q; endproperty
    a_post_body: assert property (p_post_body)
        else $error("posted slot content wrong");
    property p_post_free;
        wr_full |-> rd_zero_q && rd_addr_q == mem_addr_q;
    endproperty
    a_post_free: assert property (p_post_free)
        else $error("post into slot not read free");
    property p_rel_zero;
        wr_rel |-> mem_wdata_q[7:0] == 8'h00 && !rd_zero_q
            && rd_addr_q == mem_addr_q;
    endproperty
    a_rel_zero: assert property (p_rel_zero)
        else $error("release write wrong");
    property p_irq_post; wr_full && mem_ack && !other_irq_pending
        |-> ##1 irq_mbi_full_q; endproperty
    a_irq_post: assert property (p_irq_post)
        else $error("no incoming interrupt after post");
    property p_irq_mask; $rose(host_irq_q) |-> !$past(other_irq_pending);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt raised over pending one");
    property p_exec_hold;
        exec_valid_q && !exec_ready |=> exec_valid_q
            && $stable(exec_ccb_q) && $stable(exec_unit_q);
    endproperty
    a_exec_hold: assert property (p_exec_hold)
        else $error("dispatch dropped before taken");
    c_post: cover property (wr_full && mem_ack);
    c_release: cover property (wr_rel && mem_ack);
    c_refused: cover property (init_refused_q);
endmodule

bind hmt_mailbox_engine hmt_mailbox_engine_chk u_chk (
    .clk, .reset_n, .init_valid, .init_done_q, .init_refused_q, .mem_req_q,
    .mem_we_q, .mem_be_q, .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata,
    .exec_valid_q, .exec_unit_q, .exec_ccb_q, .exec_ready, .done_valid,
    .done_status, .done_ccb, .done_ready_q, .other_irq_pending,
    .irq_mbi_full_q, .host_irq_q
);

// [verif/hmt_host_mem.sv]
`timescale 1ns/1ps
module hmt_host_mem (
    // Clock and reset
    input  wire         clk,
    input  wire         reset_n,
    // Adds three wait cycles
    input  wire         slow,
    // Engine port
    input  wire         mem_req_q,
    input  wire         mem_we_q,
    input  wire  [3:0]  mem_be_q,
    input  wire  [23:0] mem_addr_q,
    input  wire  [31:0] mem_wdata_q,
    output logic        mem_ack,
    output logic [31:0] mem_rdata
);
    // Only the low address byte decodes, so high bytes alias
    logic [7:0] mem [0:255];
    logic [1:0] wait_q;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack   <= 1'b0;
            wait_q    <= 2'h0;
            mem_rdata <= 32'h5a5ac3c3;
        end else if (mem_ack || !mem_req_q || wait_q != 2'h0) begin
            // Released data lines never hold the last value
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q <= (mem_ack || !mem_req_q) ? {slow, slow} : wait_q - 2'h1;
        end else begin
            mem_ack <= 1'b1;
            for (int i = 0; i < 4; i++) begin
                mem_rdata[8*i +: 8] <= mem[mem_addr_q[7:0] + 8'(i)];
                if (mem_we_q && mem_be_q[i])
                    mem[mem_addr_q[7:0] + 8'(i)] <= mem_wdata_q[8*i +: 8];
            end
        end
    end
endmodule

// [verif/host_mailbox_task_engine_bench.sv]
`timescale 1ns/1ps
module host_mailbox_task_engine_bench;
    logic        clk = 0, reset_n = 0, init_valid = 0, doorbell = 0;
    logic        exec_ready = 0, done_valid = 0, mbo_avail_en = 0;
    logic        other_irq_pending = 0, irq_ack = 0, slow = 0;
    logic [23:0] init_base = 24'h000040, done_ccb = 24'h000000;
    logic [7:0]  init_count = 8'h04, done_status = 8'h00;
    logic [5:0]  done_unit = 6'h00;
    wire         init_done_q, init_refused_q, mem_req_q, mem_we_q, mem_ack;
    wire         exec_valid_q, done_ready_q, irq_mbi_full_q, host_irq_q;
    wire         irq_mbo_avail_q;
    wire  [3:0]  mem_be_q;
    wire  [23:0] mem_addr_q, exec_ccb_q;
    wire  [31:0] mem_wdata_q, mem_rdata;
    wire  [5:0]  exec_unit_q;
    logic [31:0] seed = 32'hbf92;
    logic [63:0] busy = 64'h0;
    logic [29:0] pend[$], taken[$];
    int          posted[$];
    int          mismatches = 0, checks = 0, cyc = 0, incoming_slot = 0, blk = -1;
    int          nt = 0, k;
    hmt_mailbox_engine u_dut (
        .clk, .reset_n, .init_valid, .init_base, .init_count, .init_done_q,
        .init_refused_q, .doorbell, .mem_req_q, .mem_we_q, .mem_be_q,
        .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata, .exec_valid_q,
        .exec_unit_q, .exec_ccb_q, .exec_ready, .done_valid, .done_unit,
        .done_status, .done_ccb, .done_ready_q, .mbo_avail_en,
        .other_irq_pending, .irq_ack, .irq_mbi_full_q, .irq_mbo_avail_q,
        .host_irq_q
    );
    hmt_host_mem u_mem (
        .clk, .reset_n, .slow, .mem_req_q, .mem_we_q, .mem_be_q,
        .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata
    );
    initial forever #20 clk = ~clk;
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        if (++cyc == 20000) begin
            mismatches++;
            test_done;
        end
    end
    always @(negedge clk) begin
        exec_ready <= rnd() > 32'h60000000;
        slow <= rnd() > 32'h80000000;
    end
    // Reference queue: per unit the oldest pending task must leave first
    always @(posedge clk) begin
        if (exec_valid_q && exec_ready) begin
            chk("unit idle", busy[exec_unit_q], 0);
            busy[exec_unit_q] = 1'b1;
            k = 0;
            while (k < pend.size() && pend[k][29:24] != exec_unit_q) k++;
            chk("exec ccb", exec_ccb_q, pend[k][23:0]);
            if (k < pend.size()) pend.delete(k);
            taken.push_back({exec_unit_q, exec_ccb_q});
        end
        if (done_valid && done_ready_q) busy[done_unit] = 1'b0;
    end
    task init_req(input logic ok);
        int n;
        @(negedge clk);
        init_valid = 1;
        @(negedge clk);
        init_valid = 0;
        n = 0;
        while (!(init_done_q || init_refused_q) && n++ < 4) @(negedge clk);
        chk("init done", init_done_q, ok);
        chk("init refused", init_refused_q, !ok);
    endtask
    task launch(input int s, input logic [5:0] u);
        logic [23:0] c;
        c = {8'h3a, 8'(nt), 8'h80 + 8'(s * 16)};
        nt++;
        @(negedge clk);
        u_mem.mem['h81 + s * 16] = {u[5:3], 2'(rnd()), u[2:0]};
        {u_mem.mem['h41 + 4 * s], u_mem.mem['h42 + 4 * s],
         u_mem.mem['h43 + 4 * s]} = c;
        u_mem.mem['h40 + 4 * s] = 8'h01 + 8'(rnd() % 254);
        pend.push_back({u, c});
    endtask
    task ring;
        @(negedge clk);
        doorbell = 1;
        @(negedge clk);
        doorbell = 0;
    endtask
    task complete(input logic [29:0] t);
        int a, n;
        logic [7:0] st;
        st = 8'(rnd() % 255 + 1);
        @(negedge clk);
        done_valid = 1;
        {done_unit, done_ccb} = t;
        done_status = st;
        n = 0;
        @(posedge clk);
        while (!done_ready_q && n++ < 300) @(posedge clk);
        @(negedge clk);
        done_valid = 0;
        if (incoming_slot == blk) incoming_slot = (incoming_slot + 1) % 4;
        a = 'h50 + 4 * incoming_slot;
        incoming_slot = (incoming_slot + 1) % 4;
        n = 0;
        while (u_mem.mem[a] == 0 && n++ < 300) @(negedge clk);
        chk("in status", u_mem.mem[a], st);
        chk("in ccb", {u_mem.mem[a + 1], u_mem.mem[a + 2],
            u_mem.mem[a + 3]}, t[23:0]);
        posted.push_back(a);
    endtask
    task service;
        int n;
        n = 0;
        while (!host_irq_q && n++ < 20) @(negedge clk);
        chk("host irq", host_irq_q, 1);
        while (posted.size() > 0) u_mem.mem[posted.pop_front()] = 8'h00;
        irq_ack = 1;
        @(negedge clk);
        irq_ack = 0;
    endtask
    task drain(input int cnt, input bit svc);
        int n;
        repeat (cnt) begin
            n = 0;
            while (taken.size() == 0 && n++ < 400) @(negedge clk);
            chk("task taken", taken.size() != 0, 1);
            if (taken.size() != 0) complete(taken.pop_front());
            if (svc) service;
        end
    endtask
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1;
        init_req(1);
        $display("test init done");
        for (int s = 0; s < 4; s++) launch(s, rnd() % 2 ? 6'h0a : 6'h31);
        ring;
        // Tasks are outstanding, so the engine is not idle
        init_req(0);
        drain(4, 1);
        for (int s = 0; s < 4; s++)
            chk("out freed", u_mem.mem['h40 + 4 * s], 0);
        $display("test batch one done");
        blk = incoming_slot;
        u_mem.mem['h50 + 4 * blk] = 8'hee;
        other_irq_pending = 1;
        mbo_avail_en = 1;
        for (int s = 0; s < 3; s++) launch(s, rnd() % 2 ? 6'h0a : 6'h31);
        ring;
        ring;
        drain(3, 0);
        chk("irq held", host_irq_q, 0);
        other_irq_pending = 0;
        service;
        u_mem.mem['h50 + 4 * blk] = 8'h00;
        $display("test batch two done");
        init_req(1);
        $display("test reinit done");
        test_done;
    end
endmodule
